/* ccp_conv_model.sv */
// Model of the conversion sequencer that consumes the converter clock and triggers.
`timescale 1ns/1ps
module ccp_conv_model
(
	input wire clk_i,
	input wire rst_i,
	input wire tick_i,
	input wire trig_i,
	input wire slow_i,
	output reg busy_o,
	output reg done_o
);
	reg [3:0] left_q; // Converter clocks left in the scan.
	// A trigger starts a scan of a few converter clocks; slow scans let halts land mid-scan.
	always @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			busy_o <= 1'b0;
			done_o <= 1'b0;
			left_q <= 4'h0;
		end
		else
		begin
			done_o <= 1'b0;
			if (trig_i && !busy_o)
			begin
				busy_o <= 1'b1;
				left_q <= slow_i ? 4'hf : 4'h2;
			end
			else if (busy_o && tick_i)
			begin
				left_q <= left_q - 4'h1;
				busy_o <= left_q != 4'h0;
				done_o <= left_q == 4'h0;
			end
		end
	end
endmodule // ccp_conv_model

/* ccp_defs.vh */
// Constants for the converter clock prescaler and interval timer.
`ifndef CCP_DEFS_VH
`define CCP_DEFS_VH
`define CCP_HIGH_W 5
`define CCP_LOW_W 3
`define CCP_TMR_W 17
`define CCP_RATE_W 4
`define CCP_MODE_W 3
`define CCP_HIGH_RST 5'h03
`define CCP_LOW_RST 3'h3
`define CCP_MODE_DISABLED 3'h0
`define CCP_MODE_PER_CONT 3'h6
`define CCP_MODE_INT_SINGLE 3'h7
`define CCP_RATE_MIN_LOG2 5'h07
`define CCP_RATE_MAX 4'ha
`endif

/* ccp_interval_counter.v */
// Binary divider that forms the interval timer counter.
`timescale 1ns/1ps
`include "ccp_defs.vh"
module ccp_interval_counter
(
	input wire clk_i,
	input wire rst_i,
	input wire clr_i,
	input wire tick_i,
	input wire [`CCP_RATE_W-1:0] rate_i,
	output wire expire_o,
	output wire running_o
);
	// Divider stages, one per bit.
	reg [`CCP_TMR_W-1:0] count_q;
	// Selected last count of the interval, 2^(7+rate)-1.
	wire [`CCP_TMR_W-1:0] last_w;

	assign last_w = (17'h0_0001 << (`CCP_RATE_MIN_LOG2 + {1'b0, rate_i})) - 17'h0_0001;
	assign expire_o = tick_i & ~clr_i & (count_q == last_w);
	assign running_o = (count_q != 17'h0_0000);

	// Count converter clock ticks; a clear or an expiry restarts from zero.
	always @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			count_q <= 17'h0_0000;
		else if (clr_i || expire_o)
			count_q <= 17'h0_0000;
		else if (tick_i)
			count_q <= count_q + 17'h0_0001;
	end
endmodule // ccp_interval_counter

/* ccp_prescaler_timer.v */
// Converter clock prescaler and periodic/interval timer, top level.
`timescale 1ns/1ps
`include "ccp_defs.vh"
module ccp_prescaler_timer
(
	input wire CLK_SYS_I,
	input wire RST_I,
	input wire MASTER_RST_I,
	input wire [`CCP_HIGH_W-1:0] HIGH_PHASE_COUNT_I,
	input wire [`CCP_LOW_W-1:0] LOW_PHASE_COUNT_I,
	input wire HALF_TICK_STRETCH_I,
	input wire Q2_WR_I,
	input wire [`CCP_MODE_W-1:0] Q2_MODE_I,
	input wire [`CCP_RATE_W-1:0] Q2_RATE_I,
	input wire Q2_SSE_I,
	input wire Q2_SSE_DONE_I,
	input wire STOP_I,
	input wire HALT_I,
	input wire CONV_BUSY_I,
	output reg CONVERTER_CLOCK_O,
	output reg CONVERTER_CLOCK_FALL_HALF_O,
	output reg CONVERTER_TICK_O,
	output reg TIMER_TRIGGER_O,
	output reg [`CCP_MODE_W-1:0] Q2_MODE_O,
	output reg [`CCP_RATE_W-1:0] Q2_RATE_O,
	output reg Q2_SSE_O,
	output reg TIMER_RUNNING_O
);
	// Phase states, one-hot.
	localparam ST_LOAD = 3'b001;
	localparam ST_HIGH = 3'b010;
	localparam ST_LOW = 3'b100;

	// Phase state register and its next value.
	reg [2:0] state_q;
	reg [2:0] state_d;
	// Shared 5-bit down counter and its next value.
	reg [`CCP_HIGH_W-1:0] cnt_q;
	reg [`CCP_HIGH_W-1:0] cnt_d;
	// Converter clock level next value.
	reg clk_d;
	// Stretched fall indicator next value.
	reg fall_half_d;
	// Tick pulse next value, one cycle on each converter clock rise.
	reg tick_d;
	// Halt pending: waits for the running conversion to finish.
	reg halt_wait_q;
	// Halt holding the timer in reset.
	reg halt_hold_q;
	// Timer expiry and run status from the divider.
	wire expire_w;
	wire running_w;
	// Timer mode decode.
	wire timer_mode_w;
	wire new_timer_mode_w;
	wire hold_w;
	wire halt_rise_w;
	wire clr_w;

	// Phase sequencer. The high count loads at each high start, but the low count is
	// compared live, so it acts at once; a mid-conversion change may corrupt that result.
	always @*
	begin
		state_d = state_q;
		cnt_d = cnt_q;
		clk_d = CONVERTER_CLOCK_O;
		fall_half_d = CONVERTER_CLOCK_FALL_HALF_O;
		tick_d = 1'b0;
		case (state_q)
			ST_LOAD:
			begin
				// Start of a high phase: load high count, raise the clock.
				cnt_d = HIGH_PHASE_COUNT_I;
				clk_d = 1'b1;
				fall_half_d = 1'b0;
				tick_d = 1'b1;
				state_d = ST_HIGH;
			end
			ST_HIGH:
			begin
				// Zero detector ends the high phase after count+1 cycles.
				fall_half_d = 1'b0;
				if (cnt_q == 5'h0_0)
				begin
					state_d = ST_LOW;
					cnt_d = 5'h1_f;
					// The fall is launched here so the low phase gets all its cycles.
					clk_d = 1'b0;
					// With stretch the real fall is a half cycle late.
					fall_half_d = HALF_TICK_STRETCH_I;
				end
				else
					cnt_d = cnt_q - 5'h0_1;
			end
			ST_LOW:
			begin
				// The stretch flag marks only the first low cycle.
				fall_half_d = 1'b0;
				// Low ends when low bits match the complement of the low count.
				if (cnt_q[`CCP_LOW_W-1:0] == ~LOW_PHASE_COUNT_I)
				begin
					// A new high phase starts at once with a fresh load.
					state_d = ST_HIGH;
					cnt_d = HIGH_PHASE_COUNT_I;
					clk_d = 1'b1;
					tick_d = 1'b1;
				end
				else
					cnt_d = cnt_q - 5'h0_1;
			end
			default:
			begin
				state_d = ST_LOAD;
				cnt_d = HIGH_PHASE_COUNT_I;
			end
		endcase
	end

	// Prescaler registers; reset enters the load state for a high start.
	always @(posedge CLK_SYS_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			state_q <= ST_LOAD;
			cnt_q <= `CCP_HIGH_RST;
			CONVERTER_CLOCK_O <= 1'b0;
			CONVERTER_CLOCK_FALL_HALF_O <= 1'b0;
			CONVERTER_TICK_O <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			CONVERTER_CLOCK_O <= clk_d;
			CONVERTER_CLOCK_FALL_HALF_O <= fall_half_d;
			CONVERTER_TICK_O <= tick_d;
		end
	end

	// Queue 2 control word; stop clears it, a write stores it.
	always @(posedge CLK_SYS_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			Q2_MODE_O <= `CCP_MODE_DISABLED;
			Q2_RATE_O <= 4'h0;
			Q2_SSE_O <= 1'b0;
		end
		else if (STOP_I)
		begin
			Q2_MODE_O <= `CCP_MODE_DISABLED;
			Q2_RATE_O <= 4'h0;
			Q2_SSE_O <= 1'b0;
		end
		else if (Q2_WR_I)
		begin
			Q2_MODE_O <= Q2_MODE_I;
			Q2_RATE_O <= (Q2_RATE_I > `CCP_RATE_MAX) ? `CCP_RATE_MAX : Q2_RATE_I;
			Q2_SSE_O <= Q2_SSE_I;
		end
		else if (Q2_SSE_DONE_I)
			Q2_SSE_O <= 1'b0;
	end

	assign timer_mode_w = (Q2_MODE_O == `CCP_MODE_PER_CONT) ||
		(Q2_MODE_O == `CCP_MODE_INT_SINGLE);
	// A write from one timer mode to a timer mode gives a one-cycle clear.
	assign new_timer_mode_w = Q2_WR_I && !STOP_I && timer_mode_w &&
		((Q2_MODE_I == `CCP_MODE_PER_CONT) || (Q2_MODE_I == `CCP_MODE_INT_SINGLE));
	// Level holds on the timer.
	assign hold_w = !timer_mode_w ||
		((Q2_MODE_O == `CCP_MODE_INT_SINGLE) && !Q2_SSE_O) ||
		MASTER_RST_I || STOP_I || halt_hold_q;
	assign clr_w = hold_w || new_timer_mode_w;

	// Halt handling: immediate outside timer modes or if no conversion is busy, else after the
	// current conversion. The counter restarts from zero on release.
	always @(posedge CLK_SYS_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			halt_wait_q <= 1'b0;
			halt_hold_q <= 1'b0;
		end
		else if (!HALT_I)
		begin
			halt_wait_q <= 1'b0;
			halt_hold_q <= 1'b0;
		end
		else if (halt_rise_w && timer_mode_w)
		begin
			if (CONV_BUSY_I)
				halt_wait_q <= 1'b1;
			else
				halt_hold_q <= 1'b1;
		end
		else if (halt_wait_q && !CONV_BUSY_I)
		begin
			halt_wait_q <= 1'b0;
			halt_hold_q <= 1'b1;
		end
		else if (halt_rise_w)
			halt_hold_q <= 1'b1;
	end

	// Edge of the halt line.
	ccp_sync_edge u_halt_edge
	(
		.clk_i(CLK_SYS_I),
		.rst_i(RST_I),
		.level_i(HALT_I),
		.rise_o(halt_rise_w)
	);

	// Interval divider counting converter clock ticks.
	ccp_interval_counter u_timer
	(
		.clk_i(CLK_SYS_I),
		.rst_i(RST_I),
		.clr_i(clr_w),
		.tick_i(CONVERTER_TICK_O),
		.rate_i(Q2_RATE_O),
		.expire_o(expire_w),
		.running_o(running_w)
	);

	// Registered trigger and status outputs.
	always @(posedge CLK_SYS_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			TIMER_TRIGGER_O <= 1'b0;
			TIMER_RUNNING_O <= 1'b0;
		end
		else
		begin
			TIMER_TRIGGER_O <= expire_w;
			TIMER_RUNNING_O <= running_w;
		end
	end
endmodule // ccp_prescaler_timer

/* ccp_prescaler_timer_chk.sv */
// Assertion checker for the converter clock prescaler and interval timer.
`timescale 1ns/1ps
`include "ccp_defs.vh"
module ccp_prescaler_timer_chk
(
	input wire CLK_SYS_I,
	input wire RST_I,
	input wire STOP_I,
	input wire [`CCP_HIGH_W-1:0] HIGH_PHASE_COUNT_I,
	input wire [`CCP_LOW_W-1:0] LOW_PHASE_COUNT_I,
	input wire HALF_TICK_STRETCH_I,
	input wire CONVERTER_CLOCK_O,
	input wire CONVERTER_CLOCK_FALL_HALF_O,
	input wire CONVERTER_TICK_O,
	input wire TIMER_TRIGGER_O,
	input wire [`CCP_MODE_W-1:0] Q2_MODE_O,
	input wire TIMER_RUNNING_O
);
	reg lvl_q; // Clock level seen at the previous edge.
	reg [5:0] len_q; // Edges spent at that level.
	reg chg_q; // Set when the settings moved during the phase.
	wire tmr = Q2_MODE_O == `CCP_MODE_PER_CONT || Q2_MODE_O == `CCP_MODE_INT_SINGLE;
	default clocking @(posedge CLK_SYS_I); endclocking
	default disable iff (RST_I);
	// A phase in which the settings moved is not judged, since either value may apply.
	always @(posedge CLK_SYS_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			lvl_q <= 1'b0;
			len_q <= 6'h00;
			chg_q <= 1'b1;
		end
		else if (CONVERTER_CLOCK_O != lvl_q)
		begin
			lvl_q <= CONVERTER_CLOCK_O;
			len_q <= 6'h01;
			chg_q <= 1'b0;
		end
		else
		begin
			len_q <= len_q + 6'h01;
			chg_q <= chg_q | $changed(HIGH_PHASE_COUNT_I) | $changed(LOW_PHASE_COUNT_I)
				| $changed(HALF_TICK_STRETCH_I);
		end
	end
	chk_tick_on_rise: assert property (CONVERTER_TICK_O == (CONVERTER_CLOCK_O && !lvl_q))
		else $error("tick not on clock rise");
	chk_high_len: assert property (!CONVERTER_CLOCK_O && lvl_q && !chg_q
		&& !$changed(HIGH_PHASE_COUNT_I) && !$changed(LOW_PHASE_COUNT_I)
		|-> len_q == HIGH_PHASE_COUNT_I + 6'h01) else $error("high phase length wrong");
	chk_low_len: assert property (CONVERTER_CLOCK_O && !lvl_q && !chg_q
		&& !$changed(HIGH_PHASE_COUNT_I) && !$changed(LOW_PHASE_COUNT_I)
		|-> len_q == LOW_PHASE_COUNT_I + 6'h01) else $error("low phase length wrong");
	chk_stretch_fall: assert property (!CONVERTER_CLOCK_O && lvl_q && !chg_q
		&& !$changed(HALF_TICK_STRETCH_I)
		|-> CONVERTER_CLOCK_FALL_HALF_O == HALF_TICK_STRETCH_I) else $error("stretch flag wrong");
	chk_flag_place: assert property (CONVERTER_CLOCK_FALL_HALF_O |-> !CONVERTER_CLOCK_O && lvl_q)
		else $error("stretch flag off first low cycle");
	chk_trig_tick: assert property (TIMER_TRIGGER_O |-> $past(CONVERTER_TICK_O))
		else $error("trigger not after a tick");
	chk_stop_hold: assert property (STOP_I [*3] |-> !TIMER_RUNNING_O && !TIMER_TRIGGER_O)
		else $error("timer runs in stop");
	chk_stop_clear: assert property (STOP_I |=> Q2_MODE_O == `CCP_MODE_DISABLED)
		else $error("stop left queue 2 mode");
	chk_idle_mode: assert property (!tmr [*3] |-> !TIMER_RUNNING_O && !TIMER_TRIGGER_O)
		else $error("timer runs in non-timer mode");
endmodule // ccp_prescaler_timer_chk
bind ccp_prescaler_timer ccp_prescaler_timer_chk u_chk (.*);

/* ccp_prescaler_timer_test.sv */
// Self-checking testbench for the converter clock prescaler and interval timer.
`timescale 1ns/1ps
module ccp_prescaler_timer_test;
	reg clk = 1'b0, rst = 1'b1, mrst = 1'b0, str = 1'b0, wr = 1'b0, sse = 1'b0;
	reg stop = 1'b0, halt = 1'b0, slow = 1'b0;
	reg [4:0] hi = 5'h03;
	reg [2:0] lo = 3'h3, md = 3'h0;
	reg [3:0] rt = 4'h0;
	wire busy, done, cc, fh, tk, tg, run;
	wire [2:0] q2m;
	integer num_errors = 0, n_checks = 0, n, i;
	always #50 clk = ~clk;
	ccp_prescaler_timer uut (.CLK_SYS_I(clk), .RST_I(rst), .MASTER_RST_I(mrst),
		.HIGH_PHASE_COUNT_I(hi), .LOW_PHASE_COUNT_I(lo), .HALF_TICK_STRETCH_I(str),
		.Q2_WR_I(wr), .Q2_MODE_I(md), .Q2_RATE_I(rt), .Q2_SSE_I(sse), .Q2_SSE_DONE_I(done),
		.STOP_I(stop), .HALT_I(halt), .CONV_BUSY_I(busy), .CONVERTER_CLOCK_O(cc),
		.CONVERTER_CLOCK_FALL_HALF_O(fh), .CONVERTER_TICK_O(tk), .TIMER_TRIGGER_O(tg),
		.Q2_MODE_O(q2m), .Q2_RATE_O(), .Q2_SSE_O(), .TIMER_RUNNING_O(run));
	ccp_conv_model part (.clk_i(clk), .rst_i(rst), .tick_i(tk), .trig_i(tg), .slow_i(slow),
		.busy_o(busy), .done_o(done));
	task end_sim;
	begin
		$display("Checks %0d mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	end
	endtask
	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
	begin
		n_checks = n_checks + 1;
		if (got !== exp)
		begin
			num_errors = num_errors + 1;
			$display("[FAIL] %0s expected %0d seen %0d", what, exp, got);
		end
	end
	endtask
	// Inputs change and outputs are read 10 ns after a rising edge.
	task step(input integer c);
	begin
		repeat (c) @(posedge clk);
		#10;
	end
	endtask
	// Counts edges until a tick or a trigger; a hang ends the run.
	task gap(input logic trg, input integer lim);
	begin
		n = 0;
		do begin step(1); n = n + 1; end while ((trg ? tg : tk) !== 1'b1 && n < lim);
		if (n >= lim)
		begin
			chk("wait", 0, 1);
			end_sim;
		end
	end
	endtask
	task quiet(input integer c);
	begin
		i = 0;
		repeat (c) begin step(1); i = i + (tg === 1'b1); end
		chk("stray triggers", 0, i);
	end
	endtask
	task wq(input [2:0] m, input [3:0] r, input s);
	begin
		{md, rt, sse, wr} = {m, r, s, 1'b1};
		step(1);
		wr = 1'b0;
	end
	endtask
	task t_phase(input [4:0] h, input [2:0] l, input s);
	begin
		{hi, lo, str} = {h, l, s};
		gap(0, 90);
		gap(0, 90);
		gap(0, 90);
		chk("period", h + l + 2, n);
		step(h + 1);
		chk("fall flag", s, fh);
		$display("phase test done");
	end
	endtask
	task t_periodic;
	begin
		{hi, lo, str} = 9'h000;
		for (i = 0; i < 2; i = i + 1)
		begin
			wq(3'h6, i, 1'b0);
			gap(1, 1500);
			gap(1, 1500);
			chk("interval", 256 << i, n);
		end
		$display("periodic test done");
	end
	endtask
	task t_single;
	begin
		wq(3'h7, 4'h0, 1'b0);
		quiet(600);
		wq(3'h7, 4'h0, 1'b1);
		gap(1, 600);
		quiet(600);
		$display("single test done");
	end
	endtask
	task t_stop;
	begin
		wq(3'h6, 4'h0, 1'b0);
		stop = 1'b1;
		step(3);
		chk("mode in stop", 0, q2m);
		chk("run in stop", 0, run);
		wq(3'h6, 4'h0, 1'b0);
		stop = 1'b0;
		quiet(600);
		wq(3'h6, 4'h0, 1'b0);
		mrst = 1'b1;
		step(20);
		chk("run in master reset", 0, run);
		mrst = 1'b0;
		$display("stop test done");
	end
	endtask
	task t_halt;
	begin
		wq(3'h6, 4'h0, 1'b0);
		step(40);
		halt = 1'b1;
		step(3);
		chk("run in halt", 0, run);
		halt = 1'b0;
		gap(1, 600);
		chk("restart", 1, n >= 256 && n <= 262);
		slow = 1'b1;
		gap(1, 600);
		step(4);
		halt = 1'b1;
		step(3);
		chk("run during scan", 1, run);
		n = 0;
		while (busy === 1'b1 && n < 100) begin step(1); n = n + 1; end
		step(4);
		chk("run after scan", 0, run);
		{halt, slow} = 2'b00;
		$display("halt test done");
	end
	endtask
	initial
	begin
		step(4);
		rst = 1'b0;
		step(1);
		chk("first rise", 2'b11, {cc, tk});
		t_phase(5'h03, 3'h3, 1'b0);
		t_phase(5'h00, 3'h0, 1'b0);
		t_phase(5'h1f, 3'h7, 1'b0);
		t_phase(5'h03, 3'h3, 1'b1);
		t_phase(5'h07, 3'h7, 1'b1);
		t_periodic;
		t_single;
		t_stop;
		t_halt;
		end_sim;
	end
endmodule // ccp_prescaler_timer_test

/* ccp_sync_edge.v */
// Rising-edge detector on an already synchronous level.
`timescale 1ns/1ps
module ccp_sync_edge
(
	input wire clk_i,
	input wire rst_i,
	input wire level_i,
	output wire rise_o
);
	// Previous value of the level.
	reg prev_q;

	// Remember the level each cycle so a rise lasts one cycle.
	always @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			prev_q <= 1'b0;
		else
			prev_q <= level_i;
	end

	assign rise_o = level_i & ~prev_q;
endmodule // ccp_sync_edge
